/* File: hdl/mcu_external_bus_pins.sv */
`timescale 1ns/10ps
// Functional notes
// (R1) Reset source holds reset low over 2 us.
// (R2) Timing output is oscillator divided by four.
// (R3) Fetch marker high during opcode fetch cycles.
// (R4) Direction high on read, low on write.
// (R5) Low address byte on low-address port.
// (R6) High address byte on high-address port.
// (R7) Data port is bidirectional external data bus.
// (R8) Single-chip: per-bit direction, push-pull ports.
// (R9) Slave mode: slave data port is bus.
// (R10) Slave mode: upper control pins form bus.
// (R11) Multifunction port pins selectable by software.
// (R12) Read strobe low while reading data.
// (R13) Write strobe low while writing data.
// (R14) Peripheral reset output high during reset.
// (R15) Board ties processor-mode pin to rail.
// (R16) Master buffer: separate input, output bytes.
// (R17) Strobes in high phase, address stable.
// (R18) Reset keeps pins idle, marker low.
module mcu_external_bus_pins
(
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        processor_mode_pin,
  input  wire logic        mem_expand_sel,
  input  wire logic        core_req,
  input  wire logic        core_wr,
  input  wire logic        core_fetch,
  input  wire logic [15:0] core_addr,
  input  wire logic [7:0]  core_wdata,
  output logic [7:0]       core_rdata,
  output logic             core_done,
  input  wire logic [7:0]  port_dir [0:6],
  input  wire logic [7:0]  port_wdata [0:6],
  output logic [7:0]       port_rdata [0:6],
  input  wire logic        slave_mode_sel,
  input  wire logic [2:0]  ext_int_sel,
  output logic [2:0]       ext_int_level,
  input  wire logic [2:0]  mf_func_sel [0:7],
  input  wire logic [7:0]  mf_func_out,
  input  wire logic [7:0]  mf_func_oe,
  input  wire logic        host_out_wr,
  input  wire logic [7:0]  host_out_data,
  input  wire logic        host_in_rd,
  output logic [7:0]       host_in_data,
  output logic             host_in_full,
  output logic             host_out_full,
  input  wire logic [7:0]  pin_in [0:6],
  output logic [7:0]       pin_out [0:6],
  output logic [7:0]       pin_oe [0:6],
  output logic             phi_out,
  output logic             sync_out,
  output logic             rw_out,
  output logic             rd_n,
  output logic             wr_n,
  output logic             peripheral_reset_out
);
  // Port indices: 0 low address, 1 high address, 2 data,
  // 3 multifunction, 4 analog input, 5 slave data, 6 slave control.
  cpu_bus_if cb ();
  logic [7:0] s1_reg [0:6];
  logic [7:0] s2_reg [0:6];
  logic [7:0] s3_reg [0:6];
  logic [7:0] pin_val_reg [0:6];
  logic [7:0] pin_val_next [0:6];
  logic       mode_s1_reg;
  logic       mode_s2_reg;
  logic       mode_reg;
  logic       mode_val_reg;
  logic       rst_out_reg;
  logic       bus_mode;
  logic [15:0] ext_addr;
  logic [7:0]  ext_wdata;
  logic        ext_oe;
  logic [7:0]  in_buf_reg;
  logic [7:0]  out_buf_reg;
  logic        in_full_reg;
  logic        out_full_reg;
  logic        prev_cs_reg;
  wire         m_cs_n   = pin_val_reg[6][3];
  wire         m_rd_n   = pin_val_reg[6][4];
  wire         m_wr_n   = pin_val_reg[6][5];
  wire         m_a0     = pin_val_reg[6][6];
  wire         m_access = prev_cs_reg & ~m_cs_n;
  wire         m_write  = m_access & ~m_wr_n & ~m_a0;
  wire         m_read   = m_access & ~m_rd_n & ~m_a0;
  wire         mode_next = (mode_s2_reg & mode_reg) |
                           (mode_val_reg & (mode_s2_reg | mode_reg));

  assign cb.req   = core_req & bus_mode;
  assign cb.wr    = core_wr;
  assign cb.fetch = core_fetch;
  assign cb.addr  = core_addr;
  assign cb.wdata = core_wdata;
  assign core_rdata = cb.rdata;
  assign core_done  = cb.done;

  // Read data comes from the filter's next value, since the filtered
  // register would still hold the previous byte at the capture edge.
  bus_cycle_seq u_seq
  (
    .core_clk     (core_clk),
    .arst_n       (arst_n),
    .bus          (cb.seq),
    .data_in_sync (pin_val_next[2]),
    .phi_out      (phi_out),
    .sync_out     (sync_out),
    .rw_out       (rw_out),
    .rd_n         (rd_n),
    .wr_n         (wr_n),
    .addr_out     (ext_addr),
    .data_out     (ext_wdata),
    .data_oe      (ext_oe)
  );

  // Mode pin is sampled after reset release; a flop cannot load it async.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mode_s1_reg <= 1'b0;
      mode_s2_reg <= 1'b0;
      mode_reg    <= 1'b0;
      mode_val_reg <= 1'b0;
      rst_out_reg <= 1'b1; // (R14)
    end
    else
    begin
      mode_s1_reg <= processor_mode_pin; // (R15)
      mode_s2_reg <= mode_s1_reg;
      mode_reg    <= mode_s2_reg;
      mode_val_reg <= mode_next;
      rst_out_reg <= 1'b0; // (R14)
    end
  end
  assign peripheral_reset_out = rst_out_reg; // (R14)
  assign bus_mode = (mode_val_reg | mem_expand_sel) & ~rst_out_reg; // (R18)

  genvar p;
  for (p = 0; p < 7; p++)
  begin : g_sync
    always_ff @(posedge core_clk or negedge arst_n)
    begin
      if (!arst_n)
      begin
        s1_reg[p]      <= 8'h00;
        s2_reg[p]      <= 8'h00;
        s3_reg[p]      <= 8'h00;
        pin_val_reg[p] <= 8'h00;
      end
      else
      begin
        s1_reg[p] <= pin_in[p];
        s2_reg[p] <= s1_reg[p];
        s3_reg[p] <= s2_reg[p];
        pin_val_reg[p] <= pin_val_next[p];
      end
    end
    assign pin_val_next[p] = (s2_reg[p] & s3_reg[p]) |
                             (pin_val_reg[p] & (s2_reg[p] | s3_reg[p]));
    assign port_rdata[p] = pin_val_reg[p];
  end

  // Each buffer byte has its own flag; a same-cycle fill beats a drain.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      in_buf_reg   <= 8'h00;
      out_buf_reg  <= 8'h00;
      in_full_reg  <= 1'b0;
      out_full_reg <= 1'b0;
      prev_cs_reg  <= 1'b1;
    end
    else
    begin
      prev_cs_reg <= m_cs_n;
      if (slave_mode_sel && m_write)
      begin
        in_buf_reg  <= pin_val_reg[5]; // (R16)
        in_full_reg <= 1'b1;
      end
      else if (host_in_rd)
      begin
        in_full_reg <= 1'b0;
      end
      if (host_out_wr)
      begin
        out_buf_reg  <= host_out_data; // (R16)
        out_full_reg <= 1'b1;
      end
      else if (slave_mode_sel && m_read)
      begin
        out_full_reg <= 1'b0;
      end
    end
  end
  assign host_in_data  = in_buf_reg;
  assign host_in_full  = in_full_reg;
  assign host_out_full = out_full_reg;

  wire m_drive = slave_mode_sel & ~m_cs_n & ~m_rd_n; // (R9)
  wire [7:0] mf_oe;
  wire [7:0] mf_out;
  for (p = 0; p < 8; p++)
  begin : g_mf
    wire alt = (mf_func_sel[p] != bus_pins_pkg::MF_SEL_IO); // (R11)
    assign mf_oe[p]  = alt ? mf_func_oe[p] : port_dir[3][p];
    assign mf_out[p] = alt ? mf_func_out[p] : port_wdata[3][p];
  end

  assign ext_int_level = pin_val_reg[6][2:0] & ext_int_sel; // (R10)

  always_comb
  begin
    for (int i = 0; i < 7; i++)
    begin
      pin_out[i] = port_wdata[i]; // (R8)
      pin_oe[i]  = rst_out_reg ? 8'h00 : port_dir[i]; // (R18)
    end
    pin_oe[4] = 8'h00;
    if (bus_mode)
    begin
      pin_out[0] = ext_addr[7:0]; // (R5)
      pin_oe[0]  = 8'hFF;
      pin_out[1] = ext_addr[15:8]; // (R6)
      pin_oe[1]  = 8'hFF;
      pin_out[2] = ext_wdata; // (R7)
      pin_oe[2]  = {8{ext_oe}};
    end
    if (!rst_out_reg)
    begin
      pin_out[3] = mf_out;
      pin_oe[3]  = mf_oe;
    end
    if (slave_mode_sel && !rst_out_reg)
    begin
      pin_out[5] = out_buf_reg; // (R9)
      pin_oe[5]  = {8{m_drive}};
      pin_oe[6]  = {5'h00, port_dir[6][2:0] & ~ext_int_sel}; // (R10)
    end
  end
endmodule

/* File: common/bus_pins_pkg.sv */
package bus_pins_pkg;
  localparam int          PORT_W        = 8;
  localparam int          ADDR_W        = 16;
  localparam int          PHI_DIV       = 4;
  localparam logic [1:0]  PHI_HIGH_PH   = 2'h2;
  localparam logic [1:0]  STROBE_PH     = 2'h2;
  localparam int          RESET_MIN_NS  = 2000;
  localparam int          CLK_NS        = 10;
  localparam int          RESET_MIN_CYC = (RESET_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0]  DIR_RESET     = 8'h00;
  localparam logic [7:0]  PORT_RESET    = 8'h00;
  localparam logic [4:0]  CTRL_MASK_RST = 5'h00;
  localparam int          CTRL_LSB      = 3;
  localparam logic [2:0]  MF_SEL_IO     = 3'h0;
  typedef enum logic [1:0] {MODE_SINGLE, MODE_MEMEXP, MODE_MICRO} proc_mode_e;
endpackage

/* File: common/cpu_bus_if.sv */
`timescale 1ns/10ps
interface cpu_bus_if;
  logic        req;
  logic        wr;
  logic        fetch;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        done;
  logic [1:0]  phase;
  modport core (output req, output wr, output fetch, output addr,
                output wdata, input rdata, input done, input phase);
  modport seq  (input req, input wr, input fetch, input addr,
                input wdata, output rdata, output done, output phase);
endinterface

/* File: hdl/bus_cycle_seq.sv */
`timescale 1ns/10ps
module bus_cycle_seq
(
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  cpu_bus_if.seq           bus,
  input  wire logic [7:0]  data_in_sync,
  output logic             phi_out,
  output logic             sync_out,
  output logic             rw_out,
  output logic             rd_n,
  output logic             wr_n,
  output logic [15:0]      addr_out,
  output logic [7:0]       data_out,
  output logic             data_oe
);
  logic [1:0]  phase_reg;
  logic        active_reg;
  logic        wr_reg;
  logic        fetch_reg;
  logic [15:0] addr_reg;
  logic [7:0]  wdata_reg;
  logic [7:0]  rdata_reg;
  wire         cycle_end = (phase_reg == 2'h3);
  wire         strobe_ph = (phase_reg == bus_pins_pkg::STROBE_PH) ||
                           (phase_reg == 2'h3);

  // Requests are latched only at cycle start so address stays stable.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      phase_reg  <= 2'h0;
      active_reg <= 1'b0;
      wr_reg     <= 1'b0;
      fetch_reg  <= 1'b0;
      addr_reg   <= 16'h0000;
      wdata_reg  <= 8'h00;
      rdata_reg  <= 8'h00;
    end
    else
    begin
      phase_reg <= phase_reg + 2'h1; // (R2)
      if (phase_reg == 2'h3)
      begin
        active_reg <= bus.req; // (R17)
        wr_reg     <= bus.req & bus.wr;
        fetch_reg  <= bus.req & bus.fetch & ~bus.wr;
        if (bus.req)
        begin
          addr_reg  <= bus.addr;
          wdata_reg <= bus.wdata;
        end
      end
      if (active_reg && !wr_reg && cycle_end)
      begin
        rdata_reg <= data_in_sync;
      end
    end
  end

  assign phi_out   = phase_reg[1]; // (R2)
  assign sync_out  = active_reg & fetch_reg; // (R3)
  assign rw_out    = ~(active_reg & wr_reg); // (R4)
  assign rd_n      = ~(active_reg & ~wr_reg & strobe_ph); // (R12)
  assign wr_n      = ~(active_reg & wr_reg & strobe_ph); // (R13)
  assign addr_out  = addr_reg; // (R5) (R6)
  assign data_out  = wdata_reg; // (R7)
  assign data_oe   = active_reg & wr_reg; // (R7)
  assign bus.rdata = rdata_reg;
  assign bus.done  = active_reg & cycle_end;
  assign bus.phase = phase_reg;
endmodule

/* File: sim/bus_pins_asserts.sv */
`timescale 1ns/10ps
module bus_pins_asserts
(
  input wire logic       core_clk,
  input wire logic       arst_n,
  input wire logic       core_done,
  input wire logic       phi_out,
  input wire logic       sync_out,
  input wire logic       rw_out,
  input wire logic       rd_n,
  input wire logic       wr_n,
  input wire logic       peripheral_reset_out,
  input wire logic [7:0] pin_out [0:6],
  input wire logic [7:0] pin_oe [0:6]
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence s_phi_hi; phi_out [*2]; endsequence
  sequence s_phi_lo; !phi_out [*2]; endsequence
  property p_phi; $rose(phi_out) |-> s_phi_hi ##1 s_phi_lo ##1 phi_out;
  endproperty
  a_phi: assert property (p_phi) else $error("phi period wrong");
  property p_rd; !rd_n |-> rw_out && phi_out; endproperty
  a_rd: assert property (p_rd) else $error("read strobe misplaced");
  property p_wr; !wr_n |-> !rw_out && phi_out; endproperty
  a_wr: assert property (p_wr) else $error("write strobe misplaced");
  property p_rd_len; $fell(rd_n) |=> !rd_n ##1 rd_n; endproperty
  a_rd_len: assert property (p_rd_len) else $error("read strobe length");
  // Address must not move under a strobe or a slow memory latches garbage.
  property p_addr; (!wr_n && !$past(wr_n)) || (!rd_n && !$past(rd_n)) |->
    $stable(pin_out[0]) && $stable(pin_out[1]) && $stable(rw_out); endproperty
  a_addr: assert property (p_addr) else $error("address moved");
  property p_sync; sync_out |-> rw_out; endproperty
  a_sync: assert property (p_sync) else $error("fetch not a read");
  property p_done; core_done |-> phi_out && !(rd_n && wr_n); endproperty
  a_done: assert property (p_done) else $error("done outside strobe");
  property p_rst; disable iff (1'b0) !arst_n |->
    peripheral_reset_out && rd_n && wr_n && !sync_out &&
    pin_oe[0] == 8'h00 && pin_oe[1] == 8'h00 && pin_oe[2] == 8'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("pins active in reset");
  property p_rel; $rose(arst_n) |=> !peripheral_reset_out; endproperty
  a_rel: assert property (p_rel) else $error("reset out stuck");
endmodule

bind mcu_external_bus_pins bus_pins_asserts u_chk (.core_clk, .arst_n,
  .core_done, .phi_out, .sync_out, .rw_out, .rd_n, .wr_n,
  .peripheral_reset_out, .pin_out, .pin_oe);

/* File: sim/ext_mem_model.sv */
`timescale 1ns/10ps
module ext_mem_model
(
  input  wire logic       core_clk,
  input  wire logic       rw_out,
  input  wire logic       wr_n,
  input  wire logic [7:0] addr_lo,
  input  wire logic [7:0] wdata,
  output logic [7:0]      rdata
);
  logic [7:0] mem_reg [0:255];
  logic [7:0] last_reg = 8'hA5;
  always_ff @(posedge core_clk)
  begin
    if (!wr_n)
      mem_reg[addr_lo] <= wdata;
    if (rw_out)
      last_reg <= mem_reg[addr_lo];
  end
  // Released lines show the inverse so a stale latch cannot pass.
  assign rdata = rw_out ? mem_reg[addr_lo] : ~last_reg;
endmodule

/* File: sim/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  logic        core_clk = 1'b0;
  logic        arst_n = 1'b1;
  logic        mode_pin = 1'b0;
  logic        mem_expand_sel = 1'b0;
  logic        core_req = 1'b0;
  logic        core_wr = 1'b0;
  logic        core_fetch = 1'b0;
  logic        slave_mode_sel = 1'b0;
  logic        host_out_wr = 1'b0;
  logic        host_in_rd = 1'b0;
  logic [15:0] core_addr = 16'h0000;
  logic [7:0]  core_wdata = 8'h00;
  logic [7:0]  host_out_data = 8'h00;
  logic [7:0]  mf_func_out = 8'h01;
  logic [7:0]  mf_func_oe = 8'h01;
  logic [2:0]  ext_int_sel = 3'h0;
  logic [2:0]  mf_func_sel [0:7];
  logic [7:0]  port_dir [0:6];
  logic [7:0]  port_wdata [0:6];
  logic [7:0]  drv [0:6];
  logic [7:0]  pin_in [0:6];
  logic [7:0]  pin_out [0:6];
  logic [7:0]  pin_oe [0:6];
  logic [7:0]  port_rdata [0:6];
  logic [7:0]  core_rdata, host_in_data, mem_d;
  logic [2:0]  ext_int_level;
  logic        core_done, host_in_full, host_out_full, phi_out, sync_out;
  logic        rw_out, rd_n, wr_n, peripheral_reset_out;
  int          n_errors = 0;
  int          n_checks = 0;

  always #5 core_clk = ~core_clk;
  always_comb
  begin
    pin_in = drv;
    pin_in[2] = mem_d;
  end

  ext_mem_model u_mem (.core_clk, .rw_out, .wr_n, .addr_lo(pin_out[0]),
    .wdata(pin_out[2]), .rdata(mem_d));
  mcu_external_bus_pins u_dut (.core_clk, .arst_n,
    .processor_mode_pin(mode_pin),
    .mem_expand_sel, .core_req, .core_wr, .core_fetch, .core_addr,
    .core_wdata, .core_rdata, .core_done, .port_dir, .port_wdata,
    .port_rdata, .slave_mode_sel, .ext_int_sel, .ext_int_level, .mf_func_sel,
    .mf_func_out, .mf_func_oe, .host_out_wr, .host_out_data, .host_in_rd,
    .host_in_data, .host_in_full, .host_out_full, .pin_in, .pin_out, .pin_oe,
    .phi_out, .sync_out, .rw_out, .rd_n, .wr_n, .peripheral_reset_out);

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d, errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic t_reset;
    repeat (bus_pins_pkg::RESET_MIN_CYC + 1) @(negedge core_clk);
    chk("reset_out", 16'h0001, peripheral_reset_out);
    chk("idle_pins", 16'h0003, {sync_out, rd_n, wr_n});
    chk("addr_oe", 16'h0000, pin_oe[0]);
    arst_n = 1'b1;
    repeat (2) @(negedge core_clk);
    chk("reset_out", 16'h0000, peripheral_reset_out);
  endtask

  task automatic t_single;
    int n_str;
    port_dir[0] = 8'h33;
    port_dir[3] = 8'h0F;
    port_wdata[3] = 8'h96;
    drv[3] = 8'hA0;
    mf_func_sel[0] = 3'h1;
    core_req = 1'b1;
    n_str = 0;
    repeat (8)
    begin
      @(negedge core_clk);
      if (rd_n !== 1'b1 || wr_n !== 1'b1)
        n_str++;
    end
    core_req = 1'b0;
    chk("refused", 16'h0000, 16'(n_str));
    chk("p0_oe", 16'h0033, pin_oe[0]);
    chk("p3_oe", 16'h000F, pin_oe[3]);
    chk("p3_out", 16'h0007, pin_out[3] & 8'h0F);
    chk("p3_in", 16'h000A, port_rdata[3][7:4]);
    mode_pin = 1'b1;
    repeat (8) @(negedge core_clk);
    chk("mode_oe", 16'hFFFF, {pin_oe[1], pin_oe[0]});
    mode_pin = 1'b0;
    repeat (8) @(negedge core_clk);
    chk("mode_off", 16'h0033, pin_oe[0]);
  endtask

  task automatic bus_op(input logic wr, input logic fetch,
                        input logic [15:0] a, input logic [7:0] d);
    int i;
    int n_str;
    int n_exp;
    n_str = 0;
    n_exp = bus_pins_pkg::PHI_DIV - bus_pins_pkg::STROBE_PH;
    core_wr = wr;
    core_fetch = fetch;
    core_addr = a;
    core_wdata = d;
    core_req = 1'b1;
    for (i = 0; i < 20 && core_done !== 1'b1; i++)
    begin
      @(negedge core_clk);
      if (rd_n === 1'b0 || wr_n === 1'b0)
      begin
        n_str++;
        chk("strobes", {wr, !wr}, {rd_n, wr_n});
        chk("rw", !wr, rw_out);
        chk("sync", fetch, sync_out);
        chk("addr", a, {pin_out[1], pin_out[0]});
        chk("addr_oe", 16'hFFFF, {pin_oe[1], pin_oe[0]});
        chk("data_oe", {8{wr}}, pin_oe[2]);
        if (wr)
          chk("wdata", d, pin_out[2]);
      end
    end
    core_req = 1'b0;
    if (i == 20)
    begin
      n_errors++;
      stop_test();
    end
    chk("strobe_len", 16'(n_exp), 16'(n_str));
    @(negedge core_clk);
    if (!wr)
      chk("rdata", d, core_rdata);
  endtask

  task automatic t_slave;
    slave_mode_sel = 1'b1;
    port_dir[6] = 8'hFF;
    ext_int_sel = 3'h5;
    drv[5] = 8'hC3;
    drv[6] = 8'h1F;
    repeat (6) @(negedge core_clk);
    chk("int_level", 16'h0005, ext_int_level);
    chk("ctrl_oe", 16'h0002, pin_oe[6]);
    drv[6] = 8'h10;
    repeat (6) @(negedge core_clk);
    chk("in_full", 16'h0001, host_in_full);
    chk("in_data", 16'h00C3, host_in_data);
    drv[6] = 8'h38;
    host_out_wr = 1'b1;
    host_out_data = 8'h5E;
    @(negedge core_clk);
    host_out_wr = 1'b0;
    repeat (6) @(negedge core_clk);
    chk("out_full", 16'h0001, host_out_full);
    chk("slave_idle", 16'h0000, pin_oe[5]);
    drv[6] = 8'h20;
    repeat (6) @(negedge core_clk);
    chk("slave_oe", 16'h00FF, pin_oe[5]);
    chk("slave_out", 16'h005E, pin_out[5]);
    chk("out_drain", 16'h0000, host_out_full);
    chk("in_kept", 16'h00C3, host_in_data);
    drv[6] = 8'h38;
    host_in_rd = 1'b1;
    @(negedge core_clk);
    host_in_rd = 1'b0;
    @(negedge core_clk);
    chk("in_clear", 16'h0000, host_in_full);
  endtask

  initial
  begin
    // A non-blocking drive at time zero gives the reset a real falling edge.
    arst_n <= 1'b0;
    foreach (drv[i])
    begin
      drv[i] = 8'h00;
      port_dir[i] = 8'h00;
      port_wdata[i] = 8'h00;
    end
    foreach (mf_func_sel[i])
      mf_func_sel[i] = 3'h0;
    t_reset();
    t_single();
    mem_expand_sel = 1'b1;
    repeat (8) @(negedge core_clk);
    bus_op(1'b1, 1'b0, 16'hA55A, 8'h3C);
    bus_op(1'b1, 1'b0, 16'h01C3, 8'h81);
    bus_op(1'b0, 1'b1, 16'hA55A, 8'h3C);
    bus_op(1'b0, 1'b0, 16'h01C3, 8'h81);
    t_slave();
    stop_test();
  end
endmodule
